// File: rtl/adc_cfg_pkg.sv
package adc_cfg_pkg;

  // Word and frame layout
  localparam int          BYTE_W         = 8;
  localparam int          ADDR_W         = 15;
  localparam int          INSTR_HI_ADDR  = 7;
  localparam int          FRAME_BITS     = 24;
  localparam int          DATA_FIRST_BIT = 16;

  // Register store
  localparam int          REG_COUNT      = 16;
  localparam int          REG_IDX_W      = 4;
  localparam logic [14:0] CFG_ADDR       = 15'h0000;
  localparam int          CFG_LSB_HI     = 6;
  localparam int          CFG_LSB_LO     = 1;
  localparam logic [7:0]  SELF_CLR_MASK  = 8'h81;
  localparam logic [7:0]  SOFT_RESET_CMD = 8'h81;
  localparam logic [7:0]  REG_RESET      = 8'h00;

  // Timing
  localparam int          CLK_PERIOD_NS       = 10;
  localparam int          SOFT_RESET_WAIT_MS  = 5;
  localparam int          SOFT_RESET_WAIT_CYC = SOFT_RESET_WAIT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int          HALF_CYC            = 4;
  localparam int          SETUP_CYC           = 8;
  localparam int          END_GAP_CYC         = 16;
  localparam int          HOST_GAP_CYC        = 24;
  localparam int          CNT_W               = 20;

  typedef enum logic [1:0] {
    PH_INSTR_HI = 2'b00,
    PH_INSTR_LO = 2'b01,
    PH_DATA     = 2'b10
  } phase_t;

  typedef enum logic [2:0] {
    H_IDLE    = 3'b000,
    H_SETUP   = 3'b001,
    H_SHIFT   = 3'b010,
    H_HOLD    = 3'b011,
    H_GAP     = 3'b100,
    H_RECOVER = 3'b101
  } host_state_t;

endpackage

// File: rtl/cfg_link_if.sv
`timescale 1ns/100ps
interface cfg_link_if;
  logic sclk;
  logic port_select_n;
  logic host_sdio_out;
  logic host_sdio_oe_n;
  logic dev_sdio_out;
  logic dev_sdio_oe_n;
  logic sdio;

  // Shared data wire with a pull-up; an enable low means that end drives
  assign sdio = !host_sdio_oe_n ? host_sdio_out : (!dev_sdio_oe_n ? dev_sdio_out : 1'b1);

  modport host (
    output sclk,
    output port_select_n,
    output host_sdio_out,
    output host_sdio_oe_n,
    input  sdio
  );

  modport device (
    input  sclk,
    input  port_select_n,
    input  sdio,
    output dev_sdio_out,
    output dev_sdio_oe_n
  );
endinterface

// File: rtl/sync2.sv
`timescale 1ns/100ps
module sync2 #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input  logic clk,
  input  logic rst,
  // Crossing
  input  logic d,
  output logic q
);
  logic meta_q;
  logic sync_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule

// File: rtl/adc_cfg_port_dev.sv
`timescale 1ns/100ps
// Functional notes
// - Three pins: shift clock, data, select.
// - Host shift clock times every data bit.
// - Transfers happen only while select low.
// - Select fall then clock rise opens frame.
// - Select held low streams bytes continuously.
// - Short select high between whole bytes only stalls; a long one ends the frame.
// - Select parked high: pins released, alternates on.
// - Data moves in whole eight-bit words.
// - First instruction bit selects read or write.
// - Reads turn data pin around, drive contents.
// - Host drives instruction, releases during readback.
// - MSB first default, LSB by config.
// - Byte registers, all readable; writable except bits 7 and 0 at 0x000, which self-clear.
// - Writing 0x81 at 0x000 soft-resets; wait.
module adc_cfg_port_dev (
  // System clock and reset
  input  logic       clk,
  input  logic       rst,
  // Serial link
  cfg_link_if.device link,
  // User side
  output logic       alt_func_en,
  output logic       soft_rst_pulse
);

  localparam int RW = adc_cfg_pkg::BYTE_W;

  // Link domain
  logic                         link_rst;
  logic                         frame_end_q;
  adc_cfg_pkg::phase_t          phase_q;
  logic [2:0]                   bit_cnt_q;
  logic [RW-1:0]                sr_q;
  logic [RW-1:0]                byte_d;
  logic                         byte_end;
  logic                         rw_q;
  logic [adc_cfg_pkg::ADDR_W-1:0] addr_q;
  logic [adc_cfg_pkg::ADDR_W-1:0] addr_inc;
  logic [adc_cfg_pkg::ADDR_W-1:0] instr_addr;
  logic [RW-1:0]                tx_q;
  logic [RW-1:0]                regs_q [adc_cfg_pkg::REG_COUNT];
  logic                         lsb_first;
  logic                         wr_en;
  logic                         soft_hit;
  logic                         mid_byte_q;
  logic                         soft_tgl_q;
  logic                         out_q;
  logic                         oe_n_q;
  // System domain
  logic                         sel_s;
  logic                         mid_s;
  logic                         soft_s;
  logic [4:0]                   gap_q;
  logic                         gap_full;
  logic                         alt_q;
  logic                         soft_prev_q;
  logic                         soft_pulse_q;

  function automatic logic [7:0] rd_byte(input logic [14:0] a);
    logic [7:0] v;
    v = adc_cfg_pkg::REG_RESET;
    if (a < 15'(adc_cfg_pkg::REG_COUNT)) begin
      v = regs_q[a[adc_cfg_pkg::REG_IDX_W-1:0]];
    end
    return v;
  endfunction

  assign link_rst   = rst | frame_end_q;
  assign lsb_first  = regs_q[0][adc_cfg_pkg::CFG_LSB_HI] | regs_q[0][adc_cfg_pkg::CFG_LSB_LO];
  // Byte as it stands including the bit taken on this edge
  assign byte_d     = lsb_first ? {link.sdio, sr_q[RW-1:1]} : {sr_q[RW-2:0], link.sdio};
  assign byte_end   = (bit_cnt_q == 3'h7);
  assign addr_inc   = addr_q + 15'h0001;
  assign instr_addr = {addr_q[14:8], byte_d};
  assign wr_en      = (phase_q == adc_cfg_pkg::PH_DATA) && byte_end && !rw_q && !link.port_select_n;
  assign soft_hit   = wr_en && (addr_q == adc_cfg_pkg::CFG_ADDR)
                      && ((byte_d & adc_cfg_pkg::SELF_CLR_MASK) != adc_cfg_pkg::REG_RESET);

  // Bit counter and frame phase; data is taken on the rising shift clock
  always_ff @(posedge link.sclk or posedge link_rst) begin
    if (link_rst) begin
      bit_cnt_q <= 3'h0;
      sr_q      <= 8'h00;
      phase_q   <= adc_cfg_pkg::PH_INSTR_HI;
    end else if (!link.port_select_n) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      sr_q      <= byte_d;
      if (byte_end) begin
        case (phase_q)
          adc_cfg_pkg::PH_INSTR_HI: phase_q <= adc_cfg_pkg::PH_INSTR_LO;
          adc_cfg_pkg::PH_INSTR_LO: phase_q <= adc_cfg_pkg::PH_DATA;
          adc_cfg_pkg::PH_DATA:     phase_q <= adc_cfg_pkg::PH_DATA;
          default:                  phase_q <= adc_cfg_pkg::PH_INSTR_HI;
        endcase
      end
    end
  end

  // Instruction decode and address walk
  always_ff @(posedge link.sclk or posedge link_rst) begin
    if (link_rst) begin
      rw_q   <= 1'b0;
      addr_q <= 15'h0000;
      tx_q   <= 8'h00;
    end else if (!link.port_select_n && byte_end) begin
      case (phase_q)
        adc_cfg_pkg::PH_INSTR_HI: begin
          rw_q           <= lsb_first ? byte_d[0] : byte_d[RW-1];
          addr_q[14:8]   <= lsb_first ? byte_d[RW-1:1] : byte_d[RW-2:0];
        end
        adc_cfg_pkg::PH_INSTR_LO: begin
          addr_q[7:0] <= byte_d;
          tx_q        <= rd_byte(instr_addr);
        end
        adc_cfg_pkg::PH_DATA: begin
          addr_q <= addr_inc;
          tx_q   <= rd_byte(addr_inc);
        end
        default: begin
          rw_q <= 1'b0;
        end
      endcase
    end
  end

  // Register store survives frame ends; only system reset or soft reset clears it
  genvar gi;
  generate
    for (gi = 0; gi < adc_cfg_pkg::REG_COUNT; gi++) begin : g_reg
      always_ff @(posedge link.sclk or posedge rst) begin
        if (rst) begin
          regs_q[gi] <= adc_cfg_pkg::REG_RESET;
        end else if (soft_hit) begin
          regs_q[gi] <= adc_cfg_pkg::REG_RESET;
        end else if (wr_en && (addr_q == 15'(gi))) begin
          regs_q[gi] <= (gi == 0) ? (byte_d & ~adc_cfg_pkg::SELF_CLR_MASK) : byte_d;
        end
      end
    end
  endgenerate

  // Tells the system side whether a byte is half done
  always_ff @(posedge link.sclk or posedge link_rst) begin
    if (link_rst) begin
      mid_byte_q <= 1'b0;
    end else if (!link.port_select_n) begin
      mid_byte_q <= !byte_end;
    end
  end

  always_ff @(posedge link.sclk or posedge rst) begin
    if (rst) begin
      soft_tgl_q <= 1'b0;
    end else if (soft_hit) begin
      soft_tgl_q <= ~soft_tgl_q;
    end
  end

  // Readback is launched on the falling edge so the host can take it on the next rise.
  // Select high releases the pin at once, without waiting for a clock edge.
  always_ff @(negedge link.sclk or posedge rst or posedge link.port_select_n) begin
    if (rst || link.port_select_n) begin
      oe_n_q <= 1'b1;
      out_q  <= 1'b0;
    end else begin
      oe_n_q <= !((phase_q == adc_cfg_pkg::PH_DATA) && rw_q);
      out_q  <= tx_q[lsb_first ? bit_cnt_q : (3'h7 - bit_cnt_q)];
    end
  end

  assign link.dev_sdio_out  = out_q;
  assign link.dev_sdio_oe_n = oe_n_q;

  // System domain: watches select to tell a stall from a frame end
  sync2 #(.RST_VAL(1'b1)) u_sel (
    .clk (clk),
    .rst (rst),
    .d   (link.port_select_n),
    .q   (sel_s)
  );

  sync2 #(.RST_VAL(1'b0)) u_mid (
    .clk (clk),
    .rst (rst),
    .d   (mid_byte_q),
    .q   (mid_s)
  );

  sync2 #(.RST_VAL(1'b0)) u_soft (
    .clk (clk),
    .rst (rst),
    .d   (soft_tgl_q),
    .q   (soft_s)
  );

  assign gap_full = (gap_q == 5'(adc_cfg_pkg::END_GAP_CYC));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gap_q <= 5'h00;
    end else if (!sel_s) begin
      gap_q <= 5'h00;
    end else if (!gap_full) begin
      gap_q <= gap_q + 5'h01;
    end
  end

  // A short high between whole bytes keeps the frame; a long one or a mid-byte one ends it.
  // Limitation: a stall must stay below the gap count or it closes the frame.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frame_end_q <= 1'b1;
      alt_q       <= 1'b0;
    end else begin
      frame_end_q <= sel_s && (mid_s || gap_full);
      alt_q       <= sel_s && gap_full;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      soft_prev_q  <= 1'b0;
      soft_pulse_q <= 1'b0;
    end else begin
      soft_prev_q  <= soft_s;
      soft_pulse_q <= soft_s ^ soft_prev_q;
    end
  end

  assign alt_func_en    = alt_q;
  assign soft_rst_pulse = soft_pulse_q;

endmodule

// File: rtl/adc_cfg_port_host.sv
`timescale 1ns/100ps
module adc_cfg_port_host #(
  parameter int RECOVER_CYC = adc_cfg_pkg::SOFT_RESET_WAIT_CYC
) (
  // System clock and reset
  input  logic        clk,
  input  logic        rst,
  // Serial link
  cfg_link_if.host    link,
  // Command side
  input  logic        lsb_first,
  input  logic        cmd_valid,
  output logic        cmd_ready,
  input  logic        cmd_read,
  input  logic [14:0] cmd_addr,
  input  logic [7:0]  cmd_wdata,
  input  logic        cmd_more,
  // Answer side
  output logic        rsp_valid,
  output logic [7:0]  rsp_data
);

  localparam int CW = adc_cfg_pkg::CNT_W;

  adc_cfg_pkg::host_state_t state_q;
  logic [CW-1:0]            cnt_q;
  logic                     ready_q;
  logic                     accept;
  logic                     bit_end;
  logic                     last_bit;
  logic [4:0]               bit_q;
  logic [23:0]              send_q;
  logic                     rd_q;
  logic                     more_q;
  logic                     soft_q;
  logic                     sclk_q;
  logic                     cs_n_q;
  logic                     oe_n_q;
  logic [7:0]               rx_q;
  logic                     rsp_valid_q;
  logic [7:0]               rsp_data_q;
  logic                     sdio_s;

  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int k = 0; k < 8; k++) begin
      r[k] = v[7-k];
    end
    return r;
  endfunction

  // Puts a byte in send order, first bit on top
  function automatic logic [7:0] order(input logic [7:0] v, input logic lsb);
    return lsb ? rev8(v) : v;
  endfunction

  assign accept   = cmd_valid && ready_q;
  assign bit_end  = (state_q == adc_cfg_pkg::H_SHIFT) && (cnt_q == CW'(2 * adc_cfg_pkg::HALF_CYC - 1));
  assign last_bit = (bit_q == 5'(adc_cfg_pkg::FRAME_BITS - 1));

  sync2 #(.RST_VAL(1'b1)) u_sdio (
    .clk (clk),
    .rst (rst),
    .d   (link.sdio),
    .q   (sdio_s)
  );

  // Sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= adc_cfg_pkg::H_IDLE;
      cnt_q   <= '0;
      ready_q <= 1'b0;
    end else begin
      cnt_q <= cnt_q + CW'(1);
      case (state_q)
        adc_cfg_pkg::H_IDLE: begin
          ready_q <= !accept;
          cnt_q   <= '0;
          if (accept) begin
            state_q <= adc_cfg_pkg::H_SETUP;
          end
        end
        adc_cfg_pkg::H_SETUP: begin
          if (cnt_q == CW'(adc_cfg_pkg::SETUP_CYC - 1)) begin
            state_q <= adc_cfg_pkg::H_SHIFT;
            cnt_q   <= '0;
          end
        end
        adc_cfg_pkg::H_SHIFT: begin
          if (bit_end) begin
            cnt_q <= '0;
            if (last_bit) begin
              state_q <= more_q ? adc_cfg_pkg::H_HOLD : adc_cfg_pkg::H_GAP;
              ready_q <= more_q;
            end
          end
        end
        adc_cfg_pkg::H_HOLD: begin
          cnt_q <= '0;
          if (accept) begin
            state_q <= adc_cfg_pkg::H_SHIFT;
            ready_q <= 1'b0;
          end
        end
        adc_cfg_pkg::H_GAP: begin
          if (cnt_q == CW'(adc_cfg_pkg::HOST_GAP_CYC - 1)) begin
            state_q <= soft_q ? adc_cfg_pkg::H_RECOVER : adc_cfg_pkg::H_IDLE;
            ready_q <= !soft_q;
            cnt_q   <= '0;
          end
        end
        adc_cfg_pkg::H_RECOVER: begin
          if (cnt_q == CW'(RECOVER_CYC - 1)) begin
            state_q <= adc_cfg_pkg::H_IDLE;
            ready_q <= 1'b1;
          end
        end
        default: begin
          state_q <= adc_cfg_pkg::H_IDLE;
        end
      endcase
    end
  end

  // Frame contents
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      send_q <= 24'h000000;
      bit_q  <= 5'h00;
      rd_q   <= 1'b0;
      more_q <= 1'b0;
      soft_q <= 1'b0;
    end else if (accept && (state_q == adc_cfg_pkg::H_IDLE)) begin
      send_q <= {order(lsb_first ? {cmd_addr[14:8], cmd_read} : {cmd_read, cmd_addr[14:8]}, lsb_first),
                 order(cmd_addr[7:0], lsb_first), order(cmd_wdata, lsb_first)};
      bit_q  <= 5'h00;
      rd_q   <= cmd_read;
      more_q <= cmd_more;
      soft_q <= !cmd_read && (cmd_addr == adc_cfg_pkg::CFG_ADDR)
                && ((cmd_wdata & adc_cfg_pkg::SOFT_RESET_CMD) != 8'h00);
    end else if (accept) begin
      send_q[23:16] <= order(cmd_wdata, lsb_first);
      bit_q         <= 5'(adc_cfg_pkg::DATA_FIRST_BIT);
      more_q        <= cmd_more;
    end else if (bit_end) begin
      send_q <= {send_q[22:0], 1'b0};
      bit_q  <= bit_q + 5'h01;
    end else if (state_q == adc_cfg_pkg::H_RECOVER) begin
      soft_q <= 1'b0;
    end
  end

  // Pins: shift clock idles low, rises mid-bit; data changes with the fall
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      oe_n_q <= 1'b1;
    end else begin
      if ((state_q == adc_cfg_pkg::H_SHIFT) && (cnt_q == CW'(adc_cfg_pkg::HALF_CYC - 1))) begin
        sclk_q <= 1'b1;
      end else if (bit_end) begin
        sclk_q <= 1'b0;
      end
      if (accept && (state_q == adc_cfg_pkg::H_IDLE)) begin
        cs_n_q <= 1'b0;
        oe_n_q <= 1'b0;
      end else if (bit_end && last_bit && !more_q) begin
        cs_n_q <= 1'b1;
        oe_n_q <= 1'b1;
      end else if (bit_end && rd_q && (bit_q == 5'(adc_cfg_pkg::DATA_FIRST_BIT - 1))) begin
        oe_n_q <= 1'b1;
      end
    end
  end

  // Readback: taken just before the rise, which leaves the synchroniser time to settle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_q        <= 8'h00;
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= 8'h00;
    end else begin
      rsp_valid_q <= 1'b0;
      if ((state_q == adc_cfg_pkg::H_SHIFT) && (cnt_q == CW'(adc_cfg_pkg::HALF_CYC - 1))
          && rd_q && (bit_q >= 5'(adc_cfg_pkg::DATA_FIRST_BIT))) begin
        rx_q <= {rx_q[6:0], sdio_s};
      end
      if (bit_end && last_bit && rd_q) begin
        rsp_valid_q <= 1'b1;
        rsp_data_q  <= order(rx_q, lsb_first);
      end
    end
  end

  assign link.sclk           = sclk_q;
  assign link.port_select_n  = cs_n_q;
  assign link.host_sdio_out  = send_q[23];
  assign link.host_sdio_oe_n = oe_n_q;
  assign cmd_ready           = ready_q;
  assign rsp_valid           = rsp_valid_q;
  assign rsp_data            = rsp_data_q;

endmodule

// File: sim/cfg_link_monitor.sv
`timescale 1ns/100ps
module cfg_link_monitor (
  // Clock and reset
  input logic clk,
  input logic rst,
  // Serial link
  input logic sclk,
  input logic port_select_n,
  input logic host_sdio_out,
  input logic host_sdio_oe_n,
  input logic dev_sdio_out,
  input logic dev_sdio_oe_n,
  input logic sdio
);
  logic       sclk_prev_q;
  logic [7:0] rise_cnt_q;
  logic       rw_q;
  logic       sclk_rise;

  // Edges of the shift clock as seen from the system clock
  assign sclk_rise = sclk && !sclk_prev_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) sclk_prev_q <= 1'b0;
    else sclk_prev_q <= sclk;
  end

  // Rises per frame; cleared while deselected since the host never stalls
  always_ff @(posedge clk or posedge rst) begin
    if (rst) rise_cnt_q <= 8'h00;
    else if (port_select_n) rise_cnt_q <= 8'h00;
    else if (sclk_rise) rise_cnt_q <= rise_cnt_q + 8'h01;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) rw_q <= 1'b0;
    else if (sclk_rise && !port_select_n && rise_cnt_q == 8'h00) rw_q <= sdio;
  end

  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (rst);

  AST_NO_CONTENTION: assert property (!(!host_sdio_oe_n && !dev_sdio_oe_n))
    else $error("Both ends drive the data wire");
  AST_DESELECT_RELEASE: assert property (port_select_n [*4] |-> dev_sdio_oe_n)
    else $error("Device drives data while deselected");
  AST_SCLK_IDLE: assert property (port_select_n |-> !sclk)
    else $error("Shift clock high outside a frame");
  AST_FRAME_SETUP: assert property ($fell(port_select_n) |-> !sclk [*8])
    else $error("Shift clock rose too soon after select fell");
  AST_SCLK_HIGH: assert property ($rose(sclk) |-> sclk [*3] ##[1:2] !sclk)
    else $error("Shift clock high phase has the wrong length");
  AST_HOST_HOLD: assert property (sclk && !host_sdio_oe_n |-> $stable(host_sdio_out))
    else $error("Host data changed while shift clock high");
  AST_DEV_HOLD: assert property (sclk && !dev_sdio_oe_n |-> $stable(dev_sdio_out))
    else $error("Device data changed while shift clock high");
  AST_TURNAROUND: assert property ($fell(dev_sdio_oe_n) |-> host_sdio_oe_n && !port_select_n && rw_q)
    else $error("Device took the data wire outside a read");
  AST_READ_DRIVES: assert property (sclk_rise && rw_q && rise_cnt_q >= 8'h10 |-> !dev_sdio_oe_n)
    else $error("Device not driving read data");
  AST_WRITE_SILENT: assert property (!rw_q && rise_cnt_q != 8'h00 |-> dev_sdio_oe_n)
    else $error("Device drives during a write frame");
  AST_ONE_DRIVER: assert property (!port_select_n && rise_cnt_q != 8'h00 |-> host_sdio_oe_n != dev_sdio_oe_n)
    else $error("Data wire not driven by exactly one end inside a frame");
  AST_WHOLE_BYTES: assert property ($rose(port_select_n) |-> rise_cnt_q[2:0] == 3'h0)
    else $error("Frame ended on a partial byte");
endmodule

// File: sim/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic        clk;
  logic        rst;
  logic        lsb_first;
  logic        cmd_valid;
  logic        cmd_ready;
  logic        cmd_read;
  logic [14:0] cmd_addr;
  logic [7:0]  cmd_wdata;
  logic        cmd_more;
  logic        rsp_valid;
  logic [7:0]  rsp_data;
  logic        soft_rst_pulse;
  logic        soft_rst_pulse2;
  logic        alt_func_en;
  logic [23:0] wire_bits;
  int          mismatches;
  int          n_compared;
  int          pulses;
  int          pulses2;

  cfg_link_if link ();
  cfg_link_if link2 ();

  adc_cfg_port_host #(.RECOVER_CYC(50)) adc_cfg_port_host_inst (.clk(clk), .rst(rst), .link(link),
    .lsb_first(lsb_first), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_more(cmd_more), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  adc_cfg_port_dev adc_cfg_port_dev_inst (.clk(clk), .rst(rst), .link(link), .alt_func_en(alt_func_en),
    .soft_rst_pulse(soft_rst_pulse));
  // Second device faces the bench directly so faults can be injected on its link
  adc_cfg_port_dev adc_cfg_port_dev_inst_b (.clk(clk), .rst(rst), .link(link2), .alt_func_en(),
    .soft_rst_pulse(soft_rst_pulse2));
  cfg_link_monitor cfg_link_monitor_inst (.clk(clk), .rst(rst), .sclk(link.sclk), .port_select_n(link.port_select_n),
    .host_sdio_out(link.host_sdio_out), .host_sdio_oe_n(link.host_sdio_oe_n), .dev_sdio_out(link.dev_sdio_out),
    .dev_sdio_oe_n(link.dev_sdio_oe_n), .sdio(link.sdio));

  always #5 clk = ~clk;

  always @(posedge clk) begin
    if (soft_rst_pulse === 1'b1) pulses++;
    if (soft_rst_pulse2 === 1'b1) pulses2++;
  end

  // Data sits still at the rise, so the wire is sampled there
  always @(posedge link.sclk) begin
    if (!link.port_select_n) wire_bits <= {wire_bits[22:0], link.sdio};
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    if (mismatches == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge clk);
    while (cmd_ready !== 1'b1 && n < 2000) begin
      n++;
      @(posedge clk);
    end
    // A host that never comes back counts against the run
    if (cmd_ready !== 1'b1) mismatches++;
  endtask

  task automatic send(input logic rd, input logic [14:0] addr, input logic [7:0] data, input logic more);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_read  <= rd;
    cmd_addr  <= addr;
    cmd_wdata <= data;
    cmd_more  <= more;
    wait_ready();
    cmd_valid <= 1'b0;
  endtask

  task automatic expect_rsp(input string what, input logic [7:0] exp);
    int n;
    n = 0;
    @(posedge clk);
    while (rsp_valid !== 1'b1 && n < 400) begin
      n++;
      @(posedge clk);
    end
    // The valid bit is part of the compare so a missing answer cannot pass on stale data
    check(what, {7'h00, rsp_valid, rsp_data}, {8'h01, exp});
  endtask

  task automatic t_basic();
    send(1'b0, 15'h0005, 8'hA5, 1'b0);
    wait_ready();
    check("write frame msb", wire_bits[15:0], 16'h05A5);
    check("write frame head", {8'h00, wire_bits[23:16]}, 16'h0000);
    send(1'b1, 15'h0005, 8'h00, 1'b0);
    expect_rsp("read reg 5", 8'hA5);
    wait_ready();
    check("read frame", wire_bits[23:8], 16'h8005);
    send(1'b1, 15'h7FFF, 8'h00, 1'b0);
    expect_rsp("read unmapped", 8'h00);
  endtask

  task automatic t_stream();
    for (int i = 0; i < 3; i++) send(1'b0, 15'h0002, 8'(8'h11 * (i + 1)), 1'(i < 2));
    for (int i = 0; i < 3; i++) begin
      send(1'b1, 15'h0002, 8'h00, 1'(i < 2));
      expect_rsp("stream read", 8'(8'h11 * (i + 1)));
    end
    send(1'b1, 15'h0003, 8'h00, 1'b0);
    expect_rsp("incremented write", 8'h22);
  endtask

  task automatic t_lsb();
    send(1'b0, 15'h0000, 8'h40, 1'b0);
    wait_ready();
    lsb_first <= 1'b1;
    send(1'b0, 15'h0007, 8'h35, 1'b0);
    wait_ready();
    check("lsb frame", wire_bits[15:0], 16'hE0AC);
    send(1'b1, 15'h0007, 8'h00, 1'b0);
    expect_rsp("lsb read", 8'h35);
    send(1'b0, 15'h0000, 8'h02, 1'b0);
    send(1'b1, 15'h0007, 8'h00, 1'b0);
    expect_rsp("lsb by low bit", 8'h35);
    send(1'b0, 15'h0000, 8'h00, 1'b0);
    wait_ready();
    lsb_first <= 1'b0;
    send(1'b1, 15'h0007, 8'h00, 1'b0);
    expect_rsp("msb again", 8'h35);
  endtask

  task automatic t_soft();
    int n;
    int cyc;
    n = pulses;
    cyc = 0;
    send(1'b0, adc_cfg_pkg::CFG_ADDR, adc_cfg_pkg::SOFT_RESET_CMD, 1'b0);
    repeat (8) @(posedge clk);
    check("secondary off in frame", 16'(alt_func_en), 16'h0000);
    while (cmd_ready !== 1'b1 && cyc < 2000) begin
      cyc++;
      @(posedge clk);
    end
    check("recovery wait", 16'(cyc >= 250 && cmd_ready === 1'b1), 16'h0001);
    check("soft reset pulse", 16'(pulses - n), 16'h0001);
    check("secondary on parked", {14'h0000, alt_func_en, link.dev_sdio_oe_n}, 16'h0003);
    send(1'b1, 15'h0005, 8'h00, 1'b0);
    expect_rsp("cleared reg", adc_cfg_pkg::REG_RESET);
    send(1'b1, adc_cfg_pkg::CFG_ADDR, 8'h00, 1'b0);
    expect_rsp("self clearing", 8'h00);
  endtask

  task automatic bb_byte(input logic [7:0] b, input int nbits);
    // Bench-made link clock: 48 ns period, its phase drifts against the system clock
    for (int i = 7; i > 7 - nbits; i--) begin
      link2.host_sdio_out <= b[i];
      #24 link2.sclk <= 1'b1;
      #24 link2.sclk <= 1'b0;
    end
  endtask

  task automatic bb_sel(input logic v, input int gap);
    @(posedge clk);
    link2.port_select_n <= v;
    repeat (gap) @(posedge clk);
  endtask

  task automatic bb_frame(input int last_bits, input int stall);
    bb_sel(1'b0, 8);
    bb_byte(8'h00, 8);
    if (stall > 0) bb_sel(1'b1, stall);
    if (stall > 0) bb_sel(1'b0, 8);
    bb_byte(8'h00, 8);
    if (stall > 0) bb_sel(1'b1, stall);
    if (stall > 0) bb_sel(1'b0, 8);
    bb_byte(8'h81, last_bits);
    bb_sel(1'b1, 24);
  endtask

  task automatic t_faults();
    int n;
    n = pulses2;
    bb_byte(8'h00, 8);
    bb_byte(8'h00, 8);
    bb_byte(8'h81, 8);
    repeat (24) @(posedge clk);
    check("clocked while deselected", 16'(pulses2 - n), 16'h0000);
    bb_frame(8, 8);
    check("stalled frame", 16'(pulses2 - n), 16'h0001);
    bb_frame(4, 0);
    check("partial byte dropped", 16'(pulses2 - n), 16'h0001);
    check("wire released", 16'(link2.dev_sdio_oe_n), 16'h0001);
    bb_frame(8, 0);
    check("frame after abort", 16'(pulses2 - n), 16'h0002);
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    finish_test();
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    lsb_first = 1'b0;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_addr = 15'h0000;
    cmd_wdata = 8'h00;
    cmd_more = 1'b0;
    link2.sclk = 1'b0;
    link2.port_select_n = 1'b1;
    link2.host_sdio_out = 1'b0;
    link2.host_sdio_oe_n = 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_basic();
    t_stream();
    t_lsb();
    t_soft();
    t_faults();
    finish_test();
  end
endmodule
